// file: cbd_bridge.sv
// cable side control: arbitration, livelock, doorbells and dma engine
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
module cbd_bridge (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [4:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    input  wire logic                 hst_cmd_i,
    output logic                      hst_retry_o,
    input  wire logic                 vme_cmd_i,
    output logic                      vme_go_o,
    output logic                      cable_err_o,
    input  wire logic                 cable_err_i,
    output logic                      berr_o,
    input  wire cbd_pkg::cbd_cab_wr_t cab_wr_i,
    output logic                      cab_wait_o,
    output logic                      cable_irq_line_o,
    input  wire logic                 cable_irq_line_i,
    output logic                      host_irq_o,
    output cbd_pkg::cbd_bus_req_t     mst_req_o,
    input  wire logic                 mst_gnt_i,
    input  wire logic                 mst_ack_i,
    input  wire logic                 mst_retry_i,
    input  wire logic [31:0]          mst_rdata_i,
    output logic                      pkt_valid_o,
    output logic      [31:0]          pkt_data_o,
    input  wire logic                 pkt_ready_i,
    input  wire logic                 pkt_valid_i,
    input  wire logic [31:0]          pkt_data_i,
    output logic                      pkt_ready_o
);
    localparam int unsigned PKT   = 1 << cbd_pkg::PKT_LOG;
    localparam int unsigned DEPTH = 1 << cbd_pkg::FIFO_LOG;

    logic                          ack_q;
    logic                          acc_wr;
    logic                          cab_wr;
    logic [31:0]                   rdata_q;
    logic [31:0]                   addr_q;
    logic [24:0]                   len_q;
    logic                          source_q;
    logic                          source_d;
    logic                          tx_irq_q;
    logic                          rx_irq_q;
    logic                          err_seen_q;
    logic [2:0]                    irq_pulse_q;
    logic                          cirq_s1_q;
    logic                          cirq_s2_q;
    logic                          cirq_s3_q;
    logic [15:0]                   ll_cnt_q;
    logic                          ll_fire;
    logic                          vme_abort_q;
    cbd_pkg::cbd_dma_t             st_q;
    logic [cbd_pkg::WCNT_W-1:0]    rd_left_q;
    logic [cbd_pkg::WCNT_W-1:0]    mv_left_q;
    logic [cbd_pkg::WCNT_W-1:0]    pkt_cnt_q;
    logic [cbd_pkg::PKT_LOG:0]     burst_q;
    logic [cbd_pkg::PKT_LOG:0]     need;
    logic [31:0]                   fifo_q [DEPTH];
    logic [cbd_pkg::FIFO_LOG-1:0]  wp_q;
    logic [cbd_pkg::FIFO_LOG-1:0]  rp_q;
    logic [cbd_pkg::FIFO_LOG:0]    cnt_q;
    logic                          push;
    logic                          pop;
    logic [31:0]                   push_data;
    logic                          start;
    logic [cbd_pkg::WCNT_W-1:0]    words;
    cbd_pkg::cbd_bus_req_t         req_q;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    // avalon handshake, one wait cycle per access
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign acc_wr            = avs_write_i & ack_q;
    assign avs_readdata_o    = rdata_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h00000000;
        end else if (avs_read_i && !ack_q) begin
            if (hit(avs_address_i, cbd_pkg::OFF_CTRL)) begin
                rdata_q <= {30'h00000000, source_q, (st_q != cbd_pkg::DMA_IDLE)};
            end else if (hit(avs_address_i, cbd_pkg::OFF_ADDR)) begin
                rdata_q <= addr_q;
            end else if (hit(avs_address_i, cbd_pkg::OFF_LEN)) begin
                rdata_q <= {7'h00, len_q};
            end else if (hit(avs_address_i, cbd_pkg::OFF_STAT)) begin
                rdata_q <= {pkt_cnt_q, cnt_q, err_seen_q, rx_irq_q, tx_irq_q,
                            (st_q != cbd_pkg::DMA_IDLE)};
            end else begin
                rdata_q <= 32'h00000000;
            end
        end
    end

    assign cab_wait_o = avs_read_i | avs_write_i;
    assign cab_wr     = cab_wr_i.wr & ~cab_wait_o;

    assign words = len_q[cbd_pkg::LEN_W-1:2];
    assign source_d = (acc_wr && hit(avs_address_i, cbd_pkg::OFF_CTRL))
                      ? avs_writedata_i[cbd_pkg::CTRL_SOURCE]
                      : (cab_wr && hit(cab_wr_i.addr, cbd_pkg::OFF_CTRL))
                      ? cab_wr_i.data[cbd_pkg::CTRL_SOURCE] : source_q;
    assign start = st_q == cbd_pkg::DMA_IDLE && len_q >= cbd_pkg::LEN_MIN
                   && len_q <= cbd_pkg::LEN_MAX
                   && ((acc_wr && hit(avs_address_i, cbd_pkg::OFF_CTRL)
                        && avs_writedata_i[cbd_pkg::CTRL_START])
                    || (cab_wr && hit(cab_wr_i.addr, cbd_pkg::OFF_CTRL)
                        && cab_wr_i.data[cbd_pkg::CTRL_START]));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            len_q    <= cbd_pkg::LEN_RST;
            source_q <= 1'b0;
        end else if (acc_wr) begin
            if (hit(avs_address_i, cbd_pkg::OFF_LEN)) begin
                len_q <= avs_writedata_i[cbd_pkg::LEN_W-1:0];
            end else if (hit(avs_address_i, cbd_pkg::OFF_CTRL)) begin
                source_q <= avs_writedata_i[cbd_pkg::CTRL_SOURCE];
            end
        end else if (cab_wr) begin
            if (hit(cab_wr_i.addr, cbd_pkg::OFF_LEN)) begin
                len_q <= cab_wr_i.data[cbd_pkg::LEN_W-1:0];
            end else if (hit(cab_wr_i.addr, cbd_pkg::OFF_CTRL)) begin
                source_q <= cab_wr_i.data[cbd_pkg::CTRL_SOURCE];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q <= cbd_pkg::ADDR_RST;
        end else if (mst_ack_i && (req_q.rd || req_q.wr)) begin
            addr_q <= addr_q + 32'h00000004;
        end else if (acc_wr && hit(avs_address_i, cbd_pkg::OFF_ADDR)) begin
            addr_q <= avs_writedata_i;
        end else if (cab_wr && hit(cab_wr_i.addr, cbd_pkg::OFF_ADDR)) begin
            addr_q <= cab_wr_i.data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_pulse_q <= 3'h0;
        end else if (acc_wr && hit(avs_address_i, cbd_pkg::OFF_CTRL)
                     && avs_writedata_i[cbd_pkg::CTRL_SEND_TX]) begin
            irq_pulse_q <= 3'(cbd_pkg::IRQ_PULSE_CYC);
        end else if (irq_pulse_q != 3'h0) begin
            irq_pulse_q <= irq_pulse_q - 3'h1;
        end
    end
    assign cable_irq_line_o = irq_pulse_q != 3'h0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cirq_s1_q <= 1'b0;
            cirq_s2_q <= 1'b0;
            cirq_s3_q <= 1'b0;
        end else begin
            cirq_s1_q <= cable_irq_line_i;
            cirq_s2_q <= cirq_s1_q;
            cirq_s3_q <= cirq_s2_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_irq_q <= 1'b0;
        end else if (cirq_s2_q && !cirq_s3_q) begin
            tx_irq_q <= 1'b1;
        end else if (acc_wr && hit(avs_address_i, cbd_pkg::OFF_ACK)
                     && avs_writedata_i[cbd_pkg::ACK_TX]) begin
            tx_irq_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_irq_q <= 1'b0;
        end else if (cab_wr && hit(cab_wr_i.addr, cbd_pkg::OFF_CTRL)
                     && cab_wr_i.data[cbd_pkg::CTRL_SEND_RX]) begin
            rx_irq_q <= 1'b1;
        end else if (acc_wr && hit(avs_address_i, cbd_pkg::OFF_ACK)
                     && avs_writedata_i[cbd_pkg::ACK_RX]) begin
            rx_irq_q <= 1'b0;
        end
    end
    assign host_irq_o = tx_irq_q | rx_irq_q;

    assign hst_retry_o = hst_cmd_i & vme_cmd_i & ~vme_abort_q;
    assign vme_go_o    = vme_cmd_i & ~vme_abort_q & ~cab_wait_o;

    assign ll_fire = ll_cnt_q == 16'(cbd_pkg::LIVELOCK_CYC - 1);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ll_cnt_q <= 16'h0000;
        end else if (vme_cmd_i && !vme_abort_q && (hst_retry_o || mst_retry_i
                     || ((req_q.rd || req_q.wr) && !mst_gnt_i))) begin
            ll_cnt_q <= ll_fire ? 16'h0000 : ll_cnt_q + 16'h0001;
        end else begin
            ll_cnt_q <= 16'h0000;
        end
    end

    // drop VME command until it ends
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vme_abort_q <= 1'b0;
            cable_err_o <= 1'b0;
            berr_o      <= 1'b0;
            err_seen_q  <= 1'b0;
        end else begin
            cable_err_o <= ll_fire && vme_cmd_i && !vme_abort_q;
            berr_o      <= cable_err_i;
            if (ll_fire && vme_cmd_i) begin
                vme_abort_q <= 1'b1;
            end else if (!vme_cmd_i) begin
                vme_abort_q <= 1'b0;
            end
            if (ll_fire && vme_cmd_i) begin
                err_seen_q <= 1'b1;
            end else if (acc_wr && hit(avs_address_i, cbd_pkg::OFF_ACK)) begin
                err_seen_q <= 1'b0;
            end
        end
    end

    // fifo shared by both roles
    assign need = (mv_left_q < cbd_pkg::WCNT_W'(PKT)) ? mv_left_q[cbd_pkg::PKT_LOG:0]
                  : (cbd_pkg::PKT_LOG+1)'(PKT);
    assign pkt_valid_o = st_q == cbd_pkg::DMA_SRC && burst_q != '0 && cnt_q != '0;
    assign pkt_data_o  = fifo_q[rp_q];
    assign pkt_ready_o = st_q == cbd_pkg::DMA_SNK && cnt_q != (cbd_pkg::FIFO_LOG+1)'(DEPTH);
    assign push = (st_q == cbd_pkg::DMA_SRC) ? (req_q.rd & mst_ack_i)
                                             : (pkt_valid_i & pkt_ready_o);
    assign push_data = (st_q == cbd_pkg::DMA_SRC) ? mst_rdata_i : pkt_data_i;
    assign pop = (st_q == cbd_pkg::DMA_SRC) ? (pkt_valid_o & pkt_ready_i)
                                            : (req_q.wr & mst_ack_i);

    always_ff @(posedge clk_i) begin
        if (push) begin
            fifo_q[wp_q] <= push_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_q + cbd_pkg::FIFO_LOG'(push);
            rp_q  <= rp_q + cbd_pkg::FIFO_LOG'(pop);
            cnt_q <= cnt_q + (cbd_pkg::FIFO_LOG+1)'(push) - (cbd_pkg::FIFO_LOG+1)'(pop);
        end
    end

    // role bit mirrors read and write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q      <= cbd_pkg::DMA_IDLE;
            rd_left_q <= '0;
            mv_left_q <= '0;
            pkt_cnt_q <= '0;
            burst_q   <= '0;
        end else begin
            case (st_q)
                cbd_pkg::DMA_IDLE: begin
                    if (start) begin
                        st_q      <= source_d ? cbd_pkg::DMA_SRC : cbd_pkg::DMA_SNK;
                        rd_left_q <= words;
                        mv_left_q <= words;
                        pkt_cnt_q <= (words + cbd_pkg::WCNT_W'(PKT - 1)) >> cbd_pkg::PKT_LOG;
                    end
                end
                cbd_pkg::DMA_SRC: begin
                    if (push) begin
                        rd_left_q <= rd_left_q - 1'b1;
                    end
                    if (burst_q == '0 && pkt_cnt_q != '0
                        && cnt_q >= (cbd_pkg::FIFO_LOG+1)'(need)) begin
                        burst_q   <= need;
                        pkt_cnt_q <= pkt_cnt_q - 1'b1;
                    end else if (pop) begin
                        burst_q   <= burst_q - 1'b1;
                        mv_left_q <= mv_left_q - 1'b1;
                    end
                    if (pkt_cnt_q == '0 && burst_q == '0) begin
                        st_q <= cbd_pkg::DMA_IDLE;
                    end
                end
                cbd_pkg::DMA_SNK: begin
                    if (burst_q == '0 && mv_left_q != '0
                        && cnt_q >= (cbd_pkg::FIFO_LOG+1)'(need)) begin
                        burst_q   <= need;
                        pkt_cnt_q <= pkt_cnt_q - 1'b1;
                    end else if (pop) begin
                        burst_q   <= burst_q - 1'b1;
                        mv_left_q <= mv_left_q - 1'b1;
                    end
                    if (mv_left_q == '0) begin
                        st_q <= cbd_pkg::DMA_IDLE;
                    end
                end
                default: begin
                    st_q <= cbd_pkg::DMA_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q <= '0;
        end else if (mst_ack_i) begin
            req_q <= '0;
        end else if (!req_q.rd && !req_q.wr) begin
            req_q.addr  <= addr_q;
            req_q.wdata <= fifo_q[rp_q];
            req_q.rd    <= st_q == cbd_pkg::DMA_SRC && rd_left_q != '0 && !push
                           && cnt_q < (cbd_pkg::FIFO_LOG+1)'(DEPTH - 1);
            req_q.wr    <= st_q == cbd_pkg::DMA_SNK && burst_q != '0 && cnt_q != '0 && !pop;
        end
    end
    assign mst_req_o = req_q;

    chk_src_push_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_q.rd && mst_ack_i |=> addr_q == $past(addr_q) + 32'h00000004)
        else $error("address did not advance after dma read");
    chk_retry_on_vme: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hst_cmd_i && vme_cmd_i && !vme_abort_q |-> hst_retry_o)
        else $error("host command not retried during VME command");
    chk_local_preempt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (avs_read_i || avs_write_i) |-> !vme_go_o)
        else $error("VME command proceeded during local access");
    chk_livelock_err: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ll_fire && vme_cmd_i && !vme_abort_q && ll_cnt_q != 16'h0000 |=> cable_err_o)
        else $error("livelock error not reported");
    chk_host_completes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ll_fire && vme_cmd_i |=> !hst_retry_o)
        else $error("host access still retried after livelock error");
    chk_tx_line_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        acc_wr && hit(avs_address_i, cbd_pkg::OFF_CTRL)
        && avs_writedata_i[cbd_pkg::CTRL_SEND_TX] |=> cable_irq_line_o [*4] ##1 !cable_irq_line_o)
        else $error("cable interrupt pulse wrong");
    chk_rx_irq_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cab_wr && hit(cab_wr_i.addr, cbd_pkg::OFF_CTRL)
        && cab_wr_i.data[cbd_pkg::CTRL_SEND_RX] |=> rx_irq_q && host_irq_o)
        else $error("receiver irq not raised");
    chk_tx_irq_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(tx_irq_q) |-> $past(cirq_s2_q) && !$past(cirq_s3_q))
        else $error("transmitter irq raised without cable edge");
    chk_pkt_decrement: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_q == cbd_pkg::DMA_SRC && burst_q == '0 && pkt_cnt_q != '0
        && cnt_q >= (cbd_pkg::FIFO_LOG+1)'(need) |=> pkt_cnt_q == $past(pkt_cnt_q) - 1'b1)
        else $error("packet count not decremented");
    chk_src_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_q == cbd_pkg::DMA_SRC && pkt_cnt_q == '0 && burst_q == '0
        |=> st_q == cbd_pkg::DMA_IDLE)
        else $error("source did not finish at zero packets");
    cov_src_run: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        st_q == cbd_pkg::DMA_SRC ##[1:200] st_q == cbd_pkg::DMA_IDLE);
    cov_snk_run: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        st_q == cbd_pkg::DMA_SNK ##[1:200] st_q == cbd_pkg::DMA_IDLE);
    cov_livelock: cover property (@(posedge clk_i) disable iff (!rst_n_i) cable_err_o);
endmodule // cbd_bridge
`default_nettype wire

// file: cbd_pkg.sv
// constants and types for the cable bridge dma and doorbell block
// Operation
// - collision: retry host command, VME proceeds
// - local register access briefly preempts VME commands
// - hardware resolves cable conflicts, no software scheme
// - livelock detected: send error, VME side BERR
// - endless retried read behind bridge: return error
// - after livelock error, host access completes
// - send transmitter bit drives cable interrupt line
// - transmitter irq cleared by own local ack
// - remote send receiver bit raises local irq
// - receiver irq cleared by local ack write
// - DMA masters both buses without processor
// - transfer lengths 4 bytes to 16M bytes
// - DMA registers reachable locally and over cable
// - source reads bus at address register
// - read word pushed to FIFO, address increments
// - full packet sent over cable, packet count decrements
// - destination writes full packet, address increments
// - transfer ends when source packet count zero
// - DMA read mirrors write with roles swapped
// - either system may start either direction
package cbd_pkg;
    localparam int unsigned PKT_LOG       = 3;
    localparam int unsigned FIFO_LOG      = 4;
    localparam int unsigned LEN_W         = 25;
    localparam int unsigned WCNT_W        = 23;
    localparam int unsigned LIVELOCK_NS   = 10000;
    localparam int unsigned CLK_NS        = 10;
    localparam int unsigned LIVELOCK_CYC  = LIVELOCK_NS / CLK_NS;
    localparam int unsigned IRQ_PULSE_CYC = 4;
    localparam logic [24:0] LEN_MIN       = 25'h0000004;
    localparam logic [24:0] LEN_MAX       = 25'h1000000;
    localparam logic [4:0]  OFF_CTRL      = 5'h00;
    localparam logic [4:0]  OFF_ADDR      = 5'h04;
    localparam logic [4:0]  OFF_LEN       = 5'h08;
    localparam logic [4:0]  OFF_STAT      = 5'h0C;
    localparam logic [4:0]  OFF_ACK       = 5'h10;
    localparam int unsigned CTRL_START    = 0;
    localparam int unsigned CTRL_SOURCE   = 1;
    localparam int unsigned CTRL_SEND_TX  = 2;
    localparam int unsigned CTRL_SEND_RX  = 3;
    localparam int unsigned ACK_TX        = 0;
    localparam int unsigned ACK_RX        = 1;
    localparam logic [31:0] ADDR_RST      = 32'h00000000;
    localparam logic [24:0] LEN_RST       = 25'h0000000;
    typedef enum logic [1:0] {DMA_IDLE, DMA_SRC, DMA_SNK} cbd_dma_t;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cbd_bus_req_t;
    typedef struct packed {
        logic        wr;
        logic [4:0]  addr;
        logic [31:0] data;
    } cbd_cab_wr_t;
endpackage

// file: cbd_peer.sv
// host bus memory model answering the dma master
`timescale 1ns/1ns
`default_nettype none
module cbd_peer (
    input  wire logic                  clk_i,
    input  wire cbd_pkg::cbd_bus_req_t req_i,
    output logic                       gnt_o,
    output logic                       ack_o,
    output logic [31:0]                rdata_o
);
    logic [1:0] dly_q = 2'h0;
    initial begin
        gnt_o = 1'b0;
        ack_o = 1'b0;
        rdata_o = 32'h0;
    end
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        gnt_o <= req_i.rd | req_i.wr;
        if ((req_i.rd | req_i.wr) && !ack_o) begin
            if (dly_q == 2'h0) begin
                ack_o <= 1'b1;
                rdata_o <= req_i.addr ^ 32'h5A5A0000;
                dly_q <= 2'($urandom);
            end else
                dly_q <= dly_q - 2'h1;
        end
    end
endmodule // cbd_peer
`default_nettype wire

// file: test_cable_bridge_dma_and_doorbell.sv
// testbench for the cable bridge block
`timescale 1ns/1ns
`default_nettype none
module test_cable_bridge_dma_and_doorbell;
    logic                  clk = 0, rst_n = 0, rd = 0, wr = 0, hst = 0, vme = 0;
    logic                  wreq, retry, go, ce, berr, cw, ql, hirq, gnt, ack, pv, pr = 0;
    logic                  pvi = 0, mrt = 0, pro;
    logic [4:0]            adr = 5'h00;
    logic [31:0]           wd = 32'h0, rdat, mrd, pd, base, pdi = 32'h0, w;
    cbd_pkg::cbd_cab_wr_t  cab = '0;
    cbd_pkg::cbd_bus_req_t req;
    logic [31:0]           exp_q[$], pkt_q[$], wq[$];
    int                    n_errors = 0, n_checks = 0, n, nq = 0;
    logic                  ce_q = 0;
    always #5 clk = ~clk;
    cbd_bridge cbd_bridge_i (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .hst_cmd_i(hst), .hst_retry_o(retry), .vme_cmd_i(vme),
        .vme_go_o(go), .cable_err_o(ce), .cable_err_i(ce), .berr_o(berr), .cab_wr_i(cab),
        .cab_wait_o(cw), .cable_irq_line_o(ql), .cable_irq_line_i(ql), .host_irq_o(hirq),
        .mst_req_o(req), .mst_gnt_i(gnt), .mst_ack_i(ack), .mst_retry_i(mrt),
        .mst_rdata_i(mrd), .pkt_valid_o(pv), .pkt_data_o(pd), .pkt_ready_i(pr),
        .pkt_valid_i(pvi), .pkt_data_i(pdi), .pkt_ready_o(pro));
    cbd_peer cbd_peer_i (.clk_i(clk), .req_i(req), .gnt_o(gnt), .ack_o(ack), .rdata_o(mrd));
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task test_done;
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        pr <= 1'($urandom);
        ce_q <= ce;
        if (ql === 1'b1) nq++;
        if (rd && wreq === 1'b0) chk(rdat, exp_q.pop_front(), "readdata");
        if (rd | wr) chk(cw, 1'b1, "cab_wait");
        if (ce_q) chk(berr, 1'b1, "berr");
        if (pv === 1'b1 && pr) chk(pd, pkt_q.pop_front(), "pkt word");
        if (ack === 1'b1 && req.wr) chk(req.addr, wq.pop_front(), "sink addr");
        if (ack === 1'b1 && req.wr) chk(req.wdata, wq.pop_front(), "sink data");
    end
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
    initial begin
        void'($urandom(32'hc0278d78));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(cbd_pkg::OFF_STAT, 32'h0);
        rdc(5'h14, 32'h0);
        bus(1'b1, cbd_pkg::OFF_CTRL, 32'h4);
        repeat (10) @(posedge clk);
        chk(32'(nq), cbd_pkg::IRQ_PULSE_CYC, "irq pulse");
        rdc(cbd_pkg::OFF_STAT, 32'h2);
        bus(1'b1, cbd_pkg::OFF_ACK, 32'h1);
        chk(hirq, 1'b0, "tx irq ack");
        cab <= '{1'b1, cbd_pkg::OFF_CTRL, 32'h8};
        @(posedge clk);
        cab <= '0;
        repeat (3) @(posedge clk);
        chk(hirq, 1'b1, "rx irq");
        bus(1'b1, cbd_pkg::OFF_ACK, 32'h2);
        chk(hirq, 1'b0, "rx irq ack");
        bus(1'b1, cbd_pkg::OFF_LEN, 32'h0);
        bus(1'b1, cbd_pkg::OFF_CTRL, 32'h3);
        rdc(cbd_pkg::OFF_STAT, 32'h0);
        base = $urandom & 32'h00FFFFF0;
        for (int i = 0; i < 10; i++) pkt_q.push_back((base + 32'(4 * i)) ^ 32'h5A5A0000);
        bus(1'b1, cbd_pkg::OFF_ADDR, base);
        bus(1'b1, cbd_pkg::OFF_LEN, 32'd40);
        bus(1'b1, cbd_pkg::OFF_CTRL, 32'h3);
        do @(posedge clk); while (pkt_q.size() != 0);
        repeat (20) @(posedge clk);
        rdc(cbd_pkg::OFF_STAT, 32'h0);
        bus(1'b1, cbd_pkg::OFF_ADDR, base);
        bus(1'b1, cbd_pkg::OFF_LEN, 32'd12);
        bus(1'b1, cbd_pkg::OFF_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            w = $urandom;
            wq.push_back(base + 32'(4 * i));
            wq.push_back(w);
            pvi <= 1'b1;
            pdi <= w;
            do @(posedge clk); while (pro !== 1'b1);
        end
        pvi <= 1'b0;
        do @(posedge clk); while (wq.size() != 0);
        repeat (20) @(posedge clk);
        rdc(cbd_pkg::OFF_STAT, 32'h0);
        for (int m = 0; m < 2; m++) begin
            hst <= !m[0];
            mrt <= m[0];
            vme <= 1'b1;
            @(posedge clk);
            chk(retry, !m[0], "retry");
            chk(go, 1'b1, "vme go");
            n = 1;
            do begin @(posedge clk); n++; end while (ce !== 1'b1 && n < 2000);
            n = int'(n >= cbd_pkg::LIVELOCK_CYC && n <= cbd_pkg::LIVELOCK_CYC + 3);
            chk(32'(n), 1'b1, "livelock");
            @(posedge clk);
            chk(retry, 1'b0, "retry freed");
            rdc(cbd_pkg::OFF_STAT, 32'h8);
            vme <= 1'b0;
            hst <= 1'b0;
            mrt <= 1'b0;
            bus(1'b1, cbd_pkg::OFF_ACK, 32'h0);
            rdc(cbd_pkg::OFF_STAT, 32'h0);
        end
        test_done();
    end
endmodule // test_cable_bridge_dma_and_doorbell
`default_nettype wire
